//--- cmc_host.sv
// Behaviour
// - Decrement-pointer write drives selected data segment
// - Segment select picks low or high half
// - Segment select low for full-word operations
// - Address-valid high with well-formed control word
// - Address-valid high means control code
`timescale 1ns/1ps
`default_nettype none
module cmc_host
  import cmc_pkg::*;
#(
  parameter int SETUP_CYCLES = SETUP_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input wire logic core_clk, // Core clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [7:0] regAddr, // Register byte address.
  input wire logic [31:0] regWdata, // Register write data.
  input wire logic regWe, // Write strobe, one cycle.
  input wire logic regRe, // Read strobe, one cycle.
  output logic [31:0] regRdata, // Read data, the cycle after the read strobe.
  output cmc_ctrl_t camCtrl, // Cycle strobe, write strobe, address valid, segment, code.
  input wire logic [31:0] dataBusIn, // Device data bus, level seen on the wire.
  output logic [31:0] dataBusOut, // Data driven toward the device.
  output logic dataBusOe, // High while this block drives the data bus.
  input wire logic validityLineInN, // Validity line as seen on the wire.
  output logic validityLineOutN, // Validity value driven toward the device.
  output logic validityLineOe, // High while this block drives the validity line.
  input wire logic [15:0] matchAddressOut, // Device match-address outputs.
  input wire logic multiMatchFlagN, // Device multiple-match flag.
  input wire logic fullFlagN // Device full flag.
);

  typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} cmc_state_t;
  localparam int SYNC_W = 51;

  cmc_state_t state_q;
  cmc_cmd_t cmd;
  cmc_cmd_t cmd_q;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [31:0] wdLo_q;
  logic [31:0] wdHi_q;
  logic [31:0] rdCap_q;
  logic [15:0] maddr_q;
  logic vbCap_q;
  logic err_q;
  logic ctrlWrite;
  logic startOk;
  logic effSeg;
  logic tmrDone;
  logic tmrLoad;
  logic [TMR_W-1:0] tmrValue;
  logic [31:0] rdMux;

  assign cmd = cmc_cmd_t'(regWdata[11:0]);
  assign ctrlWrite = regWe && (regAddr == REG_CTRL);
  // Reserved codes and commands that arrive while busy are refused.
  assign startOk = ctrlWrite && (state_q == IDLE) && isKnownOp(cmd.op, cmd.dirHigh);
  // Full-word operations force the segment low whatever software asked for.
  assign effSeg = isSegLowOp(cmd.op) ? 1'b0 : cmd.segSel;

  // Every device pin passes two flip-flops; only the second stage is read.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {dataBusIn, validityLineInN, matchAddressOut, multiMatchFlagN, fullFlagN};
      sync2_q <= sync1_q;
    end
  end

  // Phase timer reloads on each phase entry.
  always_comb begin
    tmrLoad = 1'b0;
    tmrValue = TMR_W'(SETUP_CYCLES);
    case (state_q)
      IDLE: begin
        tmrLoad = startOk;
      end
      SETUP: begin
        tmrLoad = tmrDone;
        tmrValue = TMR_W'(STROBE_CYCLES);
      end
      STROBE: begin
        tmrLoad = tmrDone;
        tmrValue = TMR_W'(HOLD_CYCLES);
      end
      default: begin
        tmrLoad = 1'b0;
      end
    endcase
  end

  cmc_timer #(.W(TMR_W)) phaseTimer (
    .core_clk(core_clk),
    .rst(rst),
    .load(tmrLoad),
    .loadValue(tmrValue),
    .done(tmrDone)
  );

  // Cycle sequencer: set up the pins, pulse the strobe, hold, release.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= IDLE;
    end else begin
      case (state_q)
        IDLE: if (startOk) state_q <= SETUP;
        SETUP: if (tmrDone) state_q <= STROBE;
        STROBE: if (tmrDone) state_q <= HOLD;
        HOLD: if (tmrDone) state_q <= IDLE;
        default: state_q <= IDLE;
      endcase
    end
  end

  // Control pins. Address valid stays high so the code bus always carries a control code.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      camCtrl <= CTRL_RST;
      cmd_q <= '0;
    end else if (startOk) begin
      cmd_q <= cmd;
      camCtrl.writeN <= cmd.dirHigh;
      camCtrl.addrValidN <= 1'b1;
      camCtrl.segSel <= effSeg;
      camCtrl.code <= {CODE_FILL, cmd.maskSel, cmd.op};
    end else if (state_q == SETUP && tmrDone) begin
      camCtrl.strobeN <= 1'b0;
    end else if (state_q == STROBE && tmrDone) begin
      camCtrl.strobeN <= 1'b1;
    end else if (state_q == HOLD && tmrDone) begin
      camCtrl.writeN <= 1'b1;
      camCtrl.segSel <= 1'b0;
    end
  end

  // Bus drive. Reads never drive, so the device can float the bus on a mismatch.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dataBusOut <= '0;
      dataBusOe <= 1'b0;
      validityLineOutN <= 1'b1;
      validityLineOe <= 1'b0;
    end else if (startOk) begin
      dataBusOut <= effSeg ? wdHi_q : wdLo_q;
      dataBusOe <= !cmd.dirHigh;
      validityLineOutN <= cmd.validityN;
      validityLineOe <= drivesValidity(cmd.op, cmd.dirHigh);
    end else if (state_q == HOLD && tmrDone) begin
      dataBusOe <= 1'b0;
      validityLineOe <= 1'b0;
    end
  end

  // Results are caught at the end of the strobe; the sync delay is inside the strobe width.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdCap_q <= '0;
      vbCap_q <= 1'b1;
      maddr_q <= '0;
    end else if (state_q == STROBE && tmrDone) begin
      maddr_q <= sync2_q[17:2];
      if (cmd_q.dirHigh) begin
        rdCap_q <= sync2_q[50:19];
        vbCap_q <= sync2_q[18];
      end
    end
  end

  // Write data halves, one per segment.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdLo_q <= '0;
      wdHi_q <= '0;
    end else if (regWe && regAddr == REG_WDLO) begin
      wdLo_q <= regWdata;
    end else if (regWe && regAddr == REG_WDHI) begin
      wdHi_q <= regWdata;
    end
  end

  // Refusal flag: a new refusal wins over a clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (ctrlWrite && !startOk) begin
      err_q <= 1'b1;
    end else if (regWe && regAddr == REG_STATUS && regWdata[STATUS_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  always_comb begin
    case (regAddr)
      REG_CTRL: rdMux = {20'h0_0000, cmd_q};
      REG_STATUS: rdMux = {27'h000_0000, vbCap_q, sync2_q[0], sync2_q[1], err_q,
                           state_q != IDLE};
      REG_WDLO: rdMux = wdLo_q;
      REG_WDHI: rdMux = wdHi_q;
      REG_RDATA: rdMux = rdCap_q;
      REG_MADDR: rdMux = {16'h0000, maddr_q};
      default: rdMux = '0;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRe ? rdMux : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_av_during_strobe: assert property (!camCtrl.strobeN |-> camCtrl.addrValidN)
    else $error("address valid low during a cycle strobe");
  a_seg_full_word: assert property (!camCtrl.strobeN && isSegLowOp(camCtrl.code[5:0])
    |-> !camCtrl.segSel)
    else $error("segment select high on a full-word operation");
  a_code_stable: assert property (!camCtrl.strobeN && $past(!camCtrl.strobeN)
    |-> $stable(camCtrl.code) && $stable(camCtrl.writeN))
    else $error("control word changed inside a strobe");
  a_strobe_width: assert property ($fell(camCtrl.strobeN) |=> !camCtrl.strobeN)
    else $error("strobe shorter than two cycles");
  a_data_half: assert property ($rose(dataBusOe)
    |-> dataBusOut == (camCtrl.segSel ? wdHi_q : wdLo_q))
    else $error("data bus half does not match segment select");
  a_dec_write_drive: assert property (!camCtrl.strobeN && !camCtrl.writeN
    && camCtrl.code[5:0] == OP_PTR_DEC |-> dataBusOe && validityLineOe)
    else $error("decrement write not driving data and validity");
  a_read_no_drive: assert property (!camCtrl.strobeN && camCtrl.writeN
    |-> !dataBusOe && !validityLineOe)
    else $error("bus driven during a read");
  a_refuse_reserved: assert property (ctrlWrite && !isKnownOp(cmd.op, cmd.dirHigh)
    |=> err_q && camCtrl.strobeN)
    else $error("reserved code not refused");

endmodule
`default_nettype wire

//--- cmc_pkg.sv
`default_nettype none
package cmc_pkg;

  // Core clock and pin timing, each time in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 60;
  localparam int HOLD_NS = 10;
  // Least times round up to whole cycles.
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

  // Software register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WDLO = 8'h08;
  localparam logic [7:0] REG_WDHI = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_MADDR = 8'h14;
  localparam int STATUS_ERR_BIT = 1;

  // Six-bit operation codes of the device.
  localparam logic [5:0] OP_PTR_DEC = 6'h27;
  localparam logic [5:0] OP_TOP_MATCH = 6'h02;
  localparam logic [5:0] OP_NEXT_FREE = 6'h01;
  localparam logic [5:0] OP_MOV_PTR = 6'h0C;
  localparam logic [5:0] OP_MOV_FREE = 6'h0D;
  localparam logic [5:0] OP_MOV_TOP = 6'h0E;
  localparam logic [5:0] OP_COMPARAND_COMPARE_OP = 6'h18;
  localparam logic [5:0] OP_CMP_BUS = 6'h19;
  localparam logic [5:0] OP_CMP_STORE = 6'h1A;
  localparam logic [5:0] OP_NEXT_MATCH = 6'h1B;
  localparam logic [5:0] OP_TERNARY = 6'h1C;
  localparam logic [2:0] CODE_FILL = 3'h0;

  // Command register layout, bit 0 upward: op, mask select, segment, validity, direction.
  typedef struct packed {
    logic dirHigh;
    logic validityN;
    logic segSel;
    logic [2:0] maskSel;
    logic [5:0] op;
  } cmc_cmd_t;

  // Control pins that travel together to the device.
  typedef struct packed {
    logic strobeN;
    logic writeN;
    logic addrValidN;
    logic segSel;
    logic [11:0] code;
  } cmc_ctrl_t;

  localparam cmc_ctrl_t CTRL_RST = '{strobeN: 1'b1, writeN: 1'b1, addrValidN: 1'b1,
                                     segSel: 1'b0, code: 12'h000};

  // Codes documented for the given direction of the write strobe.
  function automatic logic isKnownOp(input logic [5:0] op, input logic dirHigh);
    case (op)
      OP_PTR_DEC, OP_TOP_MATCH, OP_NEXT_FREE, OP_MOV_PTR, OP_MOV_TOP: isKnownOp = 1'b1;
      OP_MOV_FREE, OP_COMPARAND_COMPARE_OP, OP_CMP_BUS, OP_CMP_STORE, OP_NEXT_MATCH,
      OP_TERNARY: isKnownOp = !dirHigh;
      default: isKnownOp = 1'b0;
    endcase
  endfunction

  // Full-word operations that need the segment select held low.
  function automatic logic isSegLowOp(input logic [5:0] op);
    case (op)
      OP_MOV_PTR, OP_MOV_FREE, OP_MOV_TOP, OP_COMPARAND_COMPARE_OP, OP_TERNARY,
      OP_NEXT_MATCH: isSegLowOp = 1'b1;
      default: isSegLowOp = 1'b0;
    endcase
  endfunction

  // Array writes whose target validity comes from the validity line.
  function automatic logic drivesValidity(input logic [5:0] op, input logic dirHigh);
    case (op)
      OP_PTR_DEC, OP_TOP_MATCH, OP_NEXT_FREE, OP_MOV_PTR, OP_MOV_FREE,
      OP_MOV_TOP: drivesValidity = !dirHigh;
      default: drivesValidity = 1'b0;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- cmc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cmc_timer #(
  parameter int W = 8
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic load, // Load the count this cycle.
  input wire logic [W-1:0] loadValue, // Cycles until done, at least one.
  output logic done // High in the last cycle of the count.
);

  logic [W-1:0] cnt_q;

  // Counts down to zero; a zero count stays idle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= loadValue;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});

endmodule
`default_nettype wire

//--- cmc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmc_dev_model
  import cmc_pkg::*;
(
  input wire cmc_ctrl_t ctrl, // Host control pins.
  input wire logic [31:0] hostData, // Host data.
  input wire logic hostDataOe, // Host drives data.
  input wire logic hostValN, // Host validity.
  input wire logic hostValOe, // Host drives validity.
  output logic [31:0] busLevel, // Data bus wire.
  output logic valLevel, // Validity wire.
  output logic [15:0] matchAddr, // Match address.
  output logic multiN // Multiple-match flag.
);
  logic [63:0] mem [4];
  logic [63:0] cr, word, key, msk;
  logic [3:0] empty;
  logic [1:0] ptr;
  logic [31:0] rdHalf, lastBus, capData;
  logic drive, capValN, capValOe, more;
  cmc_ctrl_t cap;
  int hit, strobes, f;

  // A released line shows the inverse of its last level, so stale data cannot pass.
  assign busLevel = hostDataOe ? hostData : (drive ? rdHalf : ~lastBus);
  // The opcode is read directly so that a change of code re-evaluates the line.
  assign valLevel = hostValOe ? hostValN :
    ((drive && ctrl.code[5:0] == OP_PTR_DEC) ? empty[ptr] : ~hostValN);
  assign matchAddr = (hit < 0) ? 16'hFFFF : 16'(hit);
  assign multiN = !more;

  function automatic logic ptrOp();
    return ctrl.code[5:0] == OP_PTR_DEC;
  endfunction

  // Word i holds its index in both halves; word 1 starts empty.
  initial begin
    for (int i = 0; i < 4; i++) begin
      mem[i] = {16'hC0DE, 16'(i), 16'hF00D, 16'(i)};
    end
    empty = 4'h2;
    ptr = 2'h3;
    cr = 64'h0;
    drive = 1'h0;
    lastBus = 32'h0;
    hit = -1;
    strobes = 0;
    more = 1'h0;
    key = 64'h0;
    msk = 64'h0;
  end

  // Lowest index at or above the start wins; empty words never match.
  // Mask bits that are high leave their position out of the comparison.
  task automatic find(input logic [63:0] k, input logic [63:0] m, input int from);
    hit = -1;
    more = 1'h0;
    key = k;
    msk = m;
    for (int i = 3; i >= 0; i--) begin
      if (i >= from && !empty[i] && ((mem[i] ^ k) & ~m) == 64'h0) begin
        more = more || (hit >= 0);
        hit = i;
      end
    end
  endtask

  // First empty word, or -1 when full; a single device, so no cascade chain.
  task automatic freeSlot(output int s);
    s = -1;
    for (int i = 3; i >= 0; i--) begin
      if (empty[i]) s = i;
    end
  endtask

  // A read-type cycle drives the chosen half while the strobe is low.
  always @(negedge ctrl.strobeN) begin
    word = ptrOp() ? mem[ptr] : mem[hit[1:0]];
    rdHalf = ctrl.segSel ? word[63:32] : word[31:0];
    drive = ctrl.writeN && (ptrOp() || (hit >= 0 && (ctrl.code[5:0] == OP_TOP_MATCH
      || ctrl.code[5:0] == OP_NEXT_FREE)));
  end

  // Writes and compares take effect as the strobe ends.
  always @(posedge ctrl.strobeN) begin
    cap = ctrl;
    capData = hostData;
    capValN = hostValN;
    capValOe = hostValOe;
    strobes++;
    lastBus = busLevel;
    drive = 1'h0;
    case (ctrl.code[5:0])
      OP_PTR_DEC: begin
        if (!ctrl.writeN) begin
          if (ctrl.segSel) mem[ptr][63:32] = busLevel;
          else mem[ptr][31:0] = busLevel;
          empty[ptr] = valLevel;
        end
        ptr--;
      end
      // Mask registers keep their zero reset value here, so every selector updates all bits.
      OP_TOP_MATCH: begin
        if (!ctrl.writeN && hit >= 0) begin
          if (ctrl.segSel) mem[hit][63:32] = busLevel;
          else mem[hit][31:0] = busLevel;
          empty[hit] = valLevel;
        end
      end
      OP_NEXT_FREE: begin
        if (!ctrl.writeN) begin
          freeSlot(f);
          if (f >= 0) begin
            if (ctrl.segSel) mem[f][63:32] = busLevel;
            else mem[f][31:0] = busLevel;
            empty[f] = valLevel;
          end
        end else if (hit >= 0) begin
          find(key, msk, hit + 1);
        end
      end
      OP_MOV_PTR: begin
        if (!ctrl.writeN) begin
          mem[ptr] = cr;
          empty[ptr] = valLevel;
        end else begin
          cr = mem[ptr];
        end
      end
      OP_MOV_FREE: begin
        freeSlot(f);
        if (f >= 0) begin
          mem[f] = cr;
          empty[f] = valLevel;
        end
      end
      OP_MOV_TOP: begin
        if (hit >= 0 && ctrl.writeN) cr = mem[hit];
        else if (hit >= 0) begin
          mem[hit] = cr;
          empty[hit] = valLevel;
        end
      end
      OP_CMP_STORE: begin
        if (ctrl.segSel) cr[63:32] = busLevel;
        else cr[31:0] = busLevel;
        find(cr, 64'h0, 0);
      end
      OP_COMPARAND_COMPARE_OP: find(cr, 64'h0, 0);
      OP_CMP_BUS: find(ctrl.segSel ? {busLevel, cr[31:0]} : {cr[63:32], busLevel}, 64'h0, 0);
      OP_TERNARY: find({~busLevel, busLevel}, {~busLevel, busLevel}, 0);
      OP_NEXT_MATCH: if (hit >= 0) find(key, msk, hit + 1);
      default: ;
    endcase
  end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import cmc_pkg::*;
();
  logic core_clk, rst, regWe, regRe, dataBusOe, validityLineOutN, validityLineOe;
  logic valLevel, multiN;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, dataBusOut, busLevel, rdv;
  logic [15:0] matchAddr;
  cmc_ctrl_t camCtrl;
  int checked = 0;
  int miscompares = 0;
  int n0;
  // Full-word operations asked for with the high segment; the host must lower it.
  logic [11:0] segLow [7] = '{{3'h1, 3'h0, OP_MOV_PTR}, {3'h5, 3'h0, OP_MOV_PTR},
    {3'h1, 3'h0, OP_MOV_FREE}, {3'h1, 3'h0, OP_MOV_TOP}, {3'h1, 3'h0, OP_COMPARAND_COMPARE_OP},
    {3'h1, 3'h0, OP_NEXT_MATCH}, {3'h1, 3'h0, OP_TERNARY}};
  logic [6:0] segLowVal = 7'h0D;
  logic [31:0] bad [2] = '{32'h0000_003F, 32'h0000_0818};

  cmc_host dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWe(regWe), .regRe(regRe), .regRdata(regRdata), .camCtrl(camCtrl), .dataBusIn(busLevel),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe), .validityLineInN(valLevel),
    .validityLineOutN(validityLineOutN), .validityLineOe(validityLineOe),
    .matchAddressOut(matchAddr), .multiMatchFlagN(multiN), .fullFlagN(1'h1));
  cmc_dev_model dev (.ctrl(camCtrl), .hostData(dataBusOut), .hostDataOe(dataBusOe),
    .hostValN(validityLineOutN), .hostValOe(validityLineOe), .busLevel(busLevel),
    .valLevel(valLevel), .matchAddr(matchAddr), .multiN(multiN));

  // Core clock, 10 ns period.
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobes are left high so back-to-back writes need no gap.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'h1;
    regRe <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regAddr <= a;
    regRe <= 1'h1;
    regWe <= 1'h0;
    @(posedge core_clk);
    regRe <= 1'h0;
    @(posedge core_clk);
    d = regRdata;
  endtask

  // Runs one device cycle and checks the pins the device latched at strobe end.
  task automatic issue(input logic [11:0] cmd, input logic [31:0] lo, input logic [31:0] hi,
                       input logic seg, input logic valOe);
    int n;
    n = 0;
    wr(REG_WDLO, lo);
    wr(REG_WDHI, hi);
    wr(REG_CTRL, {20'h0_0000, cmd});
    rd(REG_STATUS, rdv);
    while (rdv[0] !== 1'h0 && n < 40) begin
      rd(REG_STATUS, rdv);
      n++;
    end
    chk("busy", {31'h0, rdv[0]}, 32'h0);
    chk("av", {31'h0, dev.cap.addrValidN}, 32'h1);
    chk("code", {20'h0_0000, dev.cap.code}, {23'h0, cmd[8:0]});
    chk("wr", {31'h0, dev.cap.writeN}, {31'h0, cmd[11]});
    chk("seg", {31'h0, dev.cap.segSel}, {31'h0, seg});
    chk("voe", {31'h0, dev.capValOe}, {31'h0, valOe});
    if (valOe) chk("vn", {31'h0, dev.capValN}, {31'h0, cmd[10]});
  endtask

  task automatic give_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence of device cycles.
  initial begin
    rst = 1'h1;
    regWe = 1'h0;
    regRe = 1'h0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    chk("idle", {16'h0, camCtrl}, {16'h0, CTRL_RST});
    issue({3'h3, 3'h0, OP_PTR_DEC}, 32'h1111_2222, 32'hA5A5_0F0F, 1'h1, 1'h1);
    chk("data", dev.capData, 32'hA5A5_0F0F);
    issue({3'h0, 3'h5, OP_PTR_DEC}, 32'h5A5A_0002, 32'h0, 1'h0, 1'h1);
    chk("data", dev.capData, 32'h5A5A_0002);
    issue({3'h4, 3'h0, OP_PTR_DEC}, 32'h0, 32'h0, 1'h0, 1'h0);
    rd(REG_RDATA, rdv);
    chk("rdata", rdv, 32'hF00D_0001);
    rd(REG_STATUS, rdv);
    chk("vcap", {31'h0, rdv[4]}, 32'h1);
    issue({3'h0, 3'h0, OP_CMP_STORE}, 32'h5A5A_0002, 32'h0, 1'h0, 1'h0);
    issue({3'h1, 3'h0, OP_CMP_STORE}, 32'h0, 32'hC0DE_0002, 1'h1, 1'h0);
    chk("data", dev.capData, 32'hC0DE_0002);
    issue({3'h5, 3'h0, OP_TOP_MATCH}, 32'h0, 32'h0, 1'h1, 1'h0);
    rd(REG_RDATA, rdv);
    chk("rdata", rdv, 32'hC0DE_0002);
    rd(REG_MADDR, rdv);
    chk("maddr", rdv, 32'h0000_0002);
    for (int i = 0; i < 7; i++) begin
      issue(segLow[i], 32'h0, 32'h0, 1'h0, segLowVal[i]);
    end
    // Words 0 to 2 now all hold the comparand: two advances walk the matches.
    for (int i = 0; i < 3; i++) begin
      issue({3'h0, 3'h0, (i == 0) ? OP_COMPARAND_COMPARE_OP : OP_NEXT_MATCH}, 32'h0, 32'h0, 1'h0, 1'h0);
      rd(REG_STATUS, rdv);
      chk("flags", {30'h0, rdv[3:2]}, (i == 2) ? 32'h3 : 32'h2);
    end
    n0 = dev.strobes;
    foreach (bad[i]) begin
      wr(REG_CTRL, bad[i]);
      rd(REG_STATUS, rdv);
      chk("busy", {31'h0, rdv[0]}, 32'h0);
      chk("err", {31'h0, rdv[1]}, 32'h1);
      wr(REG_STATUS, 32'h0000_0002);
      rd(REG_STATUS, rdv);
      chk("clr", {31'h0, rdv[1]}, 32'h0);
    end
    rd(8'h20, rdv);
    chk("unmapped", rdv, 32'h0);
    chk("cnt", 32'(dev.strobes), 32'(n0));
    give_verdict();
  end

  // A hang ends the run as a failure.
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
